// [csi_defines.svh]
// register offsets, field positions, reset values for the status
// event flag block; included by every file that decodes registers
`ifndef CSI_DEFINES_SVH
`define CSI_DEFINES_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define CSI_ADDR_CTRL 8'h24
`define CSI_ADDR_FLAGS 8'h26
`define CSI_ADDR_MASK 8'h27

// ----------------------------------------------------------------
// field positions, shared by flag and mask registers; the release bit is in the ctrl register
// ----------------------------------------------------------------
`define CSI_BIT_HOT 7
`define CSI_BIT_WARM 6
`define CSI_BIT_COOL 5
`define CSI_BIT_COLD 4
`define CSI_BIT_PGOOD 3
`define CSI_BIT_LOOP 2
`define CSI_EVT_LSB 2
`define CSI_EVT_MSB 7
`define CSI_BIT_RELEASE 0

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define CSI_FLAGS_RST 8'h00
`define CSI_MASK_RST 8'h00
`define CSI_CTRL_RST 1'b0
`define CSI_EVT_RST 6'h00

// ----------------------------------------------------------------
// timing: synchroniser depth for analog comparator levels
// ----------------------------------------------------------------
`define CSI_SYNC_STAGES 2

`endif

// [csi_pkg.sv]
// types for the charger status event flag block
// assumes csi_defines.svh for field widths
`include "csi_defines.svh"

package csi_pkg;

    // state of the flag block outside the synchroniser chain, registered in one place
    typedef struct packed {
        logic [7:0] flags;
        logic [7:0] mask;
        logic release_req;
        logic pending;
        logic [`CSI_SYNC_STAGES:0] primed;
        logic [5:0] prev;
        logic [7:0] rdata;
    } csi_state_type;

endpackage

// [csi_sync.sv]
// level synchroniser, a chain of flip-flops per bit
// assumes inputs arrive from outside the mclk domain
`timescale 1ns/1ps
`default_nettype none

module csi_sync #(
    parameter int WIDTH = 6,
    parameter int STAGES = 2
) (
    input wire logic mclk, // system clock
    input wire logic arst_n, // async reset, active low
    input wire logic [WIDTH-1:0] din, // asynchronous levels
    output logic [WIDTH-1:0] dout // synchronised levels
);

    logic [WIDTH-1:0] chain_q [STAGES];

    // ----------------------------------------------------------------
    // flip-flop chain; each stage is read only by the next, the last by dout
    // ----------------------------------------------------------------
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            for (int i = 0; i < STAGES; i++) begin
                chain_q[i] <= '0;
            end
        end else begin
            chain_q[0] <= din;
            for (int i = 1; i < STAGES; i++) begin
                chain_q[i] <= chain_q[i-1];
            end
        end
    end

    assign dout = chain_q[STAGES-1];

endmodule

`default_nettype wire

// [csi_status_irq.sv]
// status event flags, per-flag masks and interrupt pin release
// assumes the serial register decoder supplies byte read/write
// strobes on mclk; zone and supply levels come from analog blocks
`timescale 1ns/1ps
`include "csi_defines.svh"
`default_nettype none

module csi_status_irq (
    input wire logic mclk, // 50 MHz system clock
    input wire logic arst_n, // async reset, active low
    input wire logic battery_thermistor_hot, // thermistor in hot zone
    input wire logic battery_thermistor_warm, // thermistor in warm zone
    input wire logic battery_thermistor_cool, // thermistor in cool zone
    input wire logic battery_thermistor_cold, // thermistor in cold zone
    input wire logic input_power_good, // input supply is good
    input wire logic min_input_voltage_loop, // input loop active
    input wire logic [7:0] reg_addr, // register address
    input wire logic reg_wr, // write strobe, one cycle
    input wire logic [7:0] reg_wdata, // write data
    input wire logic reg_rd, // read strobe, one cycle
    output logic [7:0] reg_rdata, // read data, one cycle later
    output logic irq_n // interrupt pin, low when pending
);

    csi_pkg::csi_state_type s_q;
    csi_pkg::csi_state_type s_d;
    logic [5:0] live_raw;
    logic [5:0] live;
    logic [5:0] ev;
    logic [5:0] ev_pass;
    logic rd_flags;
    logic wr_mask;
    logic wr_ctrl;
    logic armed;

    // address match for a strobe
    function automatic logic hit(input logic stb, input logic [7:0] a,
                                 input logic [7:0] target);
        hit = stb && (a == target);
    endfunction

    // ----------------------------------------------------------------
    // level inputs into mclk domain
    // ----------------------------------------------------------------
    assign live_raw = {battery_thermistor_hot, battery_thermistor_warm,
                       battery_thermistor_cool, battery_thermistor_cold,
                       input_power_good, min_input_voltage_loop};

    csi_sync #(
        .WIDTH(6),
        .STAGES(`CSI_SYNC_STAGES)
    ) u_sync (
        .mclk(mclk),
        .arst_n(arst_n),
        .din(live_raw),
        .dout(live)
    );

    // ----------------------------------------------------------------
    // decode and event detection
    // ----------------------------------------------------------------
    assign rd_flags = hit(reg_rd, reg_addr, `CSI_ADDR_FLAGS);
    assign wr_mask = hit(reg_wr, reg_addr, `CSI_ADDR_MASK);
    assign wr_ctrl = hit(reg_wr, reg_addr, `CSI_ADDR_CTRL);

    // armed one cycle after the synchroniser has filled: reset levels raise no event
    assign armed = s_q.primed[`CSI_SYNC_STAGES];
    // any change in either direction is an event
    assign ev = armed ? (live ^ s_q.prev) : 6'h00;
    // masked events still flag but do not reach the pin
    assign ev_pass = ev & ~s_q.mask[`CSI_EVT_MSB:`CSI_EVT_LSB];

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        s_d.prev = live;
        s_d.primed = {s_q.primed[`CSI_SYNC_STAGES-1:0], 1'b1};
        // read clears the flags; a new event in the same cycle wins
        if (rd_flags) begin
            s_d.flags = `CSI_FLAGS_RST;
        end
        s_d.flags[`CSI_EVT_MSB:`CSI_EVT_LSB] =
            s_d.flags[`CSI_EVT_MSB:`CSI_EVT_LSB] | ev;
        if (wr_mask) begin
            s_d.mask = reg_wdata;
        end
        // release takes one cycle, then the bit drops by itself
        if (s_q.release_req) begin
            s_d.pending = 1'b0;
            s_d.release_req = 1'b0;
        end
        if (wr_ctrl) begin
            s_d.release_req = reg_wdata[`CSI_BIT_RELEASE];
        end
        if (|ev_pass) begin
            s_d.pending = 1'b1;
        end
        case (reg_addr)
            `CSI_ADDR_FLAGS: s_d.rdata = s_q.flags;
            `CSI_ADDR_MASK: s_d.rdata = s_q.mask;
            `CSI_ADDR_CTRL: s_d.rdata = {7'h00, s_q.release_req};
            default: s_d.rdata = 8'h00;
        endcase
        if (!reg_rd) begin
            s_d.rdata = s_q.rdata;
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            s_q.flags <= `CSI_FLAGS_RST;
            s_q.mask <= `CSI_MASK_RST;
            s_q.release_req <= `CSI_CTRL_RST;
            s_q.pending <= 1'b0;
            s_q.primed <= '0;
            s_q.prev <= `CSI_EVT_RST;
            s_q.rdata <= 8'h00;
        end else begin
            s_q <= s_d;
        end
    end

    assign reg_rdata = s_q.rdata;
    assign irq_n = ~s_q.pending;

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    a_hot_zone_flag: assert property (
        @(posedge mclk) disable iff (!arst_n)
        armed && (live[5] != s_q.prev[5]) |=> s_q.flags[`CSI_BIT_HOT])
        else $error("hot zone crossing not flagged");

    a_warm_zone_flag: assert property (
        @(posedge mclk) disable iff (!arst_n)
        armed && (live[4] != s_q.prev[4]) |=> s_q.flags[`CSI_BIT_WARM])
        else $error("warm zone crossing not flagged");

    a_loop_flag_both: assert property (
        @(posedge mclk) disable iff (!arst_n)
        armed && $changed(live[0]) |=> s_q.flags[`CSI_BIT_LOOP])
        else $error("regulation loop change not flagged");

    a_pgood_flag_both: assert property (
        @(posedge mclk) disable iff (!arst_n)
        armed && (live[1] != s_q.prev[1]) ##1 !rd_flags
        |=> s_q.flags[`CSI_BIT_PGOOD])
        else $error("power good change not kept flagged");

    a_cool_cold_flag: assert property (
        @(posedge mclk) disable iff (!arst_n)
        armed && (live[3:2] != s_q.prev[3:2])
        |=> |s_q.flags[`CSI_BIT_COOL:`CSI_BIT_COLD])
        else $error("cool or cold crossing not flagged");

    a_cold_zone_flag: assert property (
        @(posedge mclk) disable iff (!arst_n)
        armed && (live[2] != s_q.prev[2]) |=> s_q.flags[`CSI_BIT_COLD])
        else $error("cold zone crossing not flagged");

    a_hot_mask_quiet: assert property (
        @(posedge mclk) disable iff (!arst_n)
        !s_q.pending && s_q.mask[`CSI_BIT_HOT] && (ev == 6'h20) |=> irq_n)
        else $error("masked hot event drove the pin");

    a_hot_mask_pass: assert property (
        @(posedge mclk) disable iff (!arst_n)
        ev[5] && !s_q.mask[`CSI_BIT_HOT] |=> !irq_n)
        else $error("unmasked hot event did not drive the pin");

    a_warm_mask_quiet: assert property (
        @(posedge mclk) disable iff (!arst_n)
        !s_q.pending && (ev == 6'h10) && s_q.mask[`CSI_BIT_WARM] |=> irq_n)
        else $error("masked warm event drove the pin");

    a_mask_write: assert property (
        @(posedge mclk) disable iff (!arst_n)
        wr_mask |=> s_q.mask == $past(reg_wdata))
        else $error("mask write did not land");

    a_cool_mask_pass: assert property (
        @(posedge mclk) disable iff (!arst_n)
        ev[3] && !s_q.mask[`CSI_BIT_COOL] |=> !irq_n)
        else $error("unmasked cool event did not drive the pin");

    a_cold_mask_quiet: assert property (
        @(posedge mclk) disable iff (!arst_n)
        !s_q.pending && (ev == 6'h04) && s_q.mask[`CSI_BIT_COLD] |=> irq_n)
        else $error("masked cold event drove the pin");

    a_pgood_mask_pass: assert property (
        @(posedge mclk) disable iff (!arst_n)
        ev[1] && !s_q.mask[`CSI_BIT_PGOOD]
        |=> !irq_n ##1 !irq_n || s_q.release_req
        || $past(s_q.release_req))
        else $error("power good event lost from the pin");

    a_loop_mask_quiet: assert property (
        @(posedge mclk) disable iff (!arst_n)
        !s_q.pending && (ev == 6'h01) && s_q.mask[`CSI_BIT_LOOP] |=> irq_n)
        else $error("masked loop event drove the pin");

    a_release_start: assert property (
        @(posedge mclk) disable iff (!arst_n)
        wr_ctrl && reg_wdata[`CSI_BIT_RELEASE] |=> s_q.release_req)
        else $error("release write did not set the release bit");

    a_release_self_clear: assert property (
        @(posedge mclk) disable iff (!arst_n)
        s_q.release_req && !wr_ctrl && (ev_pass == 6'h00)
        |=> !s_q.release_req && irq_n)
        else $error("release did not complete in one cycle");

    a_flags_reserved: assert property (
        @(posedge mclk) disable iff (!arst_n)
        s_q.flags[1:0] == 2'b00 ##1 rd_flags |=> reg_rdata[1:0] == 2'b00)
        else $error("reserved flag bits read nonzero");

endmodule

`default_nettype wire

// [csi_host_model.sv]
// host side of the status event register port, byte reads and writes
// assumes mclk from the bench; requests launched 1 ns after an edge
`timescale 1ns/1ps
`default_nettype none

module csi_host_model (
    input wire logic mclk, // system clock
    output logic [7:0] reg_addr, // register address
    output logic reg_wr, // write strobe
    output logic [7:0] reg_wdata, // write data
    output logic reg_rd, // read strobe
    input wire logic [7:0] reg_rdata // read data
);
    initial begin
        reg_addr = 8'h00;
        reg_wr = 1'b0;
        reg_wdata = 8'h00;
        reg_rd = 1'b0;
    end

    // released bus shows the inverse, never a stale value
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        #1;
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(posedge mclk);
        #1;
        reg_wr = 1'b0;
        reg_addr = ~a;
        reg_wdata = ~d;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge mclk);
        #1;
        reg_addr = a;
        reg_rd = 1'b1;
        @(posedge mclk);
        #1;
        reg_rd = 1'b0;
        reg_addr = ~a;
        d = reg_rdata;
    endtask
endmodule
`default_nettype wire

// [tb_top.sv]
// self-checking bench for the status event flag block
// assumes csi_status_irq and csi_host_model are compiled before it
`timescale 1ns/1ps
`include "csi_defines.svh"
`default_nettype none

module tb_top;
    logic mclk = 1'b0;
    logic arst_n = 1'b0;
    logic [7:0] lv = 8'h00;
    logic [7:0] addr, wdata, rdata, v;
    logic wr, rd, irq_n;
    int err_count = 0;
    int tests_run = 0;

    always #10 mclk = ~mclk;

    csi_status_irq i_dut (
        .mclk(mclk), .arst_n(arst_n),
        .battery_thermistor_hot(lv[`CSI_BIT_HOT]),
        .battery_thermistor_warm(lv[`CSI_BIT_WARM]),
        .battery_thermistor_cool(lv[`CSI_BIT_COOL]),
        .battery_thermistor_cold(lv[`CSI_BIT_COLD]),
        .input_power_good(lv[`CSI_BIT_PGOOD]),
        .min_input_voltage_loop(lv[`CSI_BIT_LOOP]),
        .reg_addr(addr), .reg_wr(wr), .reg_wdata(wdata), .reg_rd(rd),
        .reg_rdata(rdata), .irq_n(irq_n));

    csi_host_model i_host (
        .mclk(mclk), .reg_addr(addr), .reg_wr(wr), .reg_wdata(wdata),
        .reg_rd(rd), .reg_rdata(rdata));

    // ----------------------------------------------------------------
    // shared checks
    // ----------------------------------------------------------------
    task automatic end_of_test();
        if (err_count == 0 && tests_run > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wait_irq(input logic lvl);
        for (int i = 0; i < 10 && irq_n !== lvl; i++) begin
            @(posedge mclk);
            #1;
        end
        chk({7'h00, irq_n}, {7'h00, lvl});
        if (irq_n !== lvl) begin
            end_of_test();
        end
    endtask

    task automatic release_irq();
        i_host.wr(`CSI_ADDR_CTRL, 8'h01);
        wait_irq(1'b1);
        i_host.rd(`CSI_ADDR_CTRL, v);
        chk(v, 8'h00);
    endtask

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_registers();
        i_host.rd(`CSI_ADDR_FLAGS, v);
        chk(v, 8'h00);
        i_host.rd(`CSI_ADDR_MASK, v);
        chk(v, 8'h00);
        i_host.wr(`CSI_ADDR_MASK, 8'hff);
        i_host.rd(`CSI_ADDR_MASK, v);
        chk(v, 8'hff);
        i_host.wr(`CSI_ADDR_MASK, 8'h00);
        i_host.wr(`CSI_ADDR_FLAGS, 8'hff);
        i_host.rd(`CSI_ADDR_FLAGS, v);
        chk(v, 8'h00);
        i_host.rd(8'h30, v);
        chk(v, 8'h00);
        chk({7'h00, irq_n}, 8'h01);
    endtask

    // entry and exit of every zone and supply change, unmasked
    task automatic t_events();
        for (int b = `CSI_EVT_LSB; b <= `CSI_EVT_MSB; b++) begin
            for (int k = 0; k < 2; k++) begin
                lv[b] = ~lv[b];
                wait_irq(1'b0);
                i_host.rd(`CSI_ADDR_FLAGS, v);
                chk(v, 8'h01 << b);
                i_host.rd(`CSI_ADDR_FLAGS, v);
                chk(v, 8'h00);
                release_irq();
            end
        end
    endtask

    // masked event keeps pin high but still flags; unmasked passes
    task automatic t_masks();
        for (int b = `CSI_EVT_LSB; b <= `CSI_EVT_MSB; b++) begin
            i_host.wr(`CSI_ADDR_MASK, 8'h01 << b);
            lv[b] = ~lv[b];
            repeat (6) @(posedge mclk);
            #1;
            chk({7'h00, irq_n}, 8'h01);
            i_host.rd(`CSI_ADDR_FLAGS, v);
            chk(v, 8'h01 << b);
            i_host.wr(`CSI_ADDR_MASK, 8'h00);
            lv[b] = ~lv[b];
            wait_irq(1'b0);
            i_host.rd(`CSI_ADDR_FLAGS, v);
            chk(v, 8'h01 << b);
            release_irq();
        end
    endtask

    // event on the edge that takes a flag read survives the clear
    task automatic t_set_wins();
        @(posedge mclk);
        #1;
        lv[`CSI_BIT_WARM] = ~lv[`CSI_BIT_WARM];
        @(posedge mclk);
        i_host.rd(`CSI_ADDR_FLAGS, v);
        chk(v, 8'h00);
        i_host.rd(`CSI_ADDR_FLAGS, v);
        chk(v, 8'h40);
        release_irq();
    endtask

    // levels held through a mid-run reset raise no event
    task automatic t_reset_levels();
        i_host.wr(`CSI_ADDR_MASK, 8'hff);
        @(posedge mclk);
        #1;
        arst_n = 1'b0;
        lv = 8'hac;
        repeat (3) @(posedge mclk);
        #1;
        chk(rdata, 8'h00);
        chk({7'h00, irq_n}, 8'h01);
        arst_n = 1'b1;
        repeat (8) @(posedge mclk);
        #1;
        chk({7'h00, irq_n}, 8'h01);
        i_host.rd(`CSI_ADDR_FLAGS, v);
        chk(v, 8'h00);
        i_host.rd(`CSI_ADDR_MASK, v);
        chk(v, 8'h00);
        lv[`CSI_BIT_HOT] = ~lv[`CSI_BIT_HOT];
        wait_irq(1'b0);
        i_host.rd(`CSI_ADDR_FLAGS, v);
        chk(v, 8'h80);
    endtask

    initial begin
        repeat (20) @(posedge mclk);
        #1;
        arst_n = 1'b1;
        repeat (4) @(posedge mclk);
        #1;
        t_registers();
        t_events();
        t_masks();
        t_set_wins();
        t_reset_levels();
        end_of_test();
    end
endmodule
`default_nettype wire
